// File: verilog/gpcfg_consts.vh
// Constants of the pin function configuration block.
// Assumes 8 ports of 8 pin slots each, pin index = port * 8 + bit.
`ifndef GPCFG_CONSTS_VH
`define GPCFG_CONSTS_VH

// ----------------------------------------------------------------------
// Register selects on the write and read ports
// ----------------------------------------------------------------------
`define GPCFG_SEL_DATA 5'h00
`define GPCFG_SEL_DIR 5'h01
`define GPCFG_SEL_SENSE 5'h02
`define GPCFG_SEL_BOTH 5'h03
`define GPCFG_SEL_EVENT 5'h04
`define GPCFG_SEL_IMASK 5'h05
`define GPCFG_SEL_RAW 5'h06
`define GPCFG_SEL_MASKED 5'h07
`define GPCFG_SEL_ICLR 5'h08
`define GPCFG_SEL_AFSEL 5'h09
`define GPCFG_SEL_DR4 5'h0a
`define GPCFG_SEL_DR8 5'h0b
`define GPCFG_SEL_DR18 5'h0c
`define GPCFG_SEL_DR2 5'h10
`define GPCFG_SEL_SLEW 5'h11
`define GPCFG_SEL_PUR 5'h12
`define GPCFG_SEL_PDR 5'h13
`define GPCFG_SEL_DEN 5'h14
`define GPCFG_SEL_ANALOG_MODE_BIT 5'h15
`define GPCFG_SEL_PCTL 5'h16
`define GPCFG_SEL_ADCEN 5'h17
`define GPCFG_SEL_ODR 5'h18

// ----------------------------------------------------------------------
// Pin population, alternate function map and reset values
// ----------------------------------------------------------------------
// Byte order H G F E D C B A; 44 pins in all.
`define GPCFG_PRESENT 64'h0303_0f3f_7f7f_ffff
// Pins that carry a peripheral function.
`define GPCFG_ALT_PRESENT 64'h0303_000f_4f6f_ffff
`define GPCFG_RST_AFSEL 64'h0000_0000_000f_0c3f
`define GPCFG_RST_DEN 64'h0000_0000_000f_0c3f
`define GPCFG_RST_PUR 64'h0000_0000_000f_0000
`define GPCFG_RST_PDR 64'h0000_0000_0000_0000
`define GPCFG_RST_PCTL_A 32'h0011_1111
`define GPCFG_RST_PCTL_B 32'h0000_1100
`define GPCFG_RST_PCTL_C 32'h0000_3333
`define GPCFG_RST_PCTL_X 32'h0000_0000

// ----------------------------------------------------------------------
// Drive codes and limits
// ----------------------------------------------------------------------
`define GPCFG_DRV_2MA 2'h0
`define GPCFG_DRV_4MA 2'h1
`define GPCFG_DRV_8MA 2'h2
`define GPCFG_DRV_18MA 2'h3
`define GPCFG_MAX_DR18 7'h04

`endif

// File: verilog/gpcfg_sync2.v
// Two-stage synchroniser for the pad inputs.
// Assumes the inputs are asynchronous to i_mclk.
`timescale 1ns/1ns
module gpcfg_sync2 #(
  parameter W = 64
) (
  input wire i_mclk,
  input wire i_nrst,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);

  reg [W-1:0] meta;

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// File: verilog/gpcfg_evt.v
// Per-pin interrupt event detector: edge or level, selectable polarity.
// Assumes i_lvl is already synchronous to i_mclk.
`timescale 1ns/1ns
module gpcfg_evt #(
  parameter W = 64
) (
  input wire i_mclk,
  input wire i_nrst,
  input wire [W-1:0] i_lvl,
  input wire [W-1:0] i_sense,
  input wire [W-1:0] i_both,
  input wire [W-1:0] i_event,
  output wire [W-1:0] o_hit
);

  reg [W-1:0] prev;
  wire [W-1:0] rise;
  wire [W-1:0] fall;
  wire [W-1:0] edge_hit;
  wire [W-1:0] level_hit;

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev <= {W{1'b0}};
    end else begin
      prev <= i_lvl;
    end
  end

  assign rise = i_lvl & ~prev;
  assign fall = ~i_lvl & prev;
  // Both-edge mode overrides the single polarity choice.
  assign edge_hit = (i_both & (rise | fall)) |
    (~i_both & ((i_event & rise) | (~i_event & fall)));
  // Level mode fires for as long as the pin sits at the chosen level.
  assign level_hit = ~(i_lvl ^ i_event);
  assign o_hit = (i_sense & level_hit) | (~i_sense & edge_hit);

endmodule

// File: verilog/gpcfg_top.v
// Pin function configuration and GPIO logic for eight 8-bit ports.
// Assumes the configuration ports are driven by logic on i_mclk and the
// pad inputs come straight from the package pins.
`timescale 1ns/1ns
`include "gpcfg_consts.vh"

// Summary of operation
// - Eight ports A to H expose 44 pins; absent slots read zero.
// - Output level can change every two clocks; data register updates in one.
// - Interrupts on rising, falling or both edges, individually maskable.
// - Level sensitive interrupt, high or low, as an alternative to edges.
// - Access mask bits select which pin bits a write or any read but a function-code read touches.
// - A pin event that newly raises its flag, with trigger enabled, pulses the converter start.
// - Per-pin pull-up, pull-down, open drain and digital input enable.
// - Drive 2, 4 or 8 mA, slew only at 8, at most four 18 mA.
// - Each pin is configured alone; no grouping between pins.
// - Unlisted pins reset to tri-stated GPIO with all settings zero.
// - Port A 0-5 and port B 2-3 reset to peripheral use, code 1.
// - Port C 0-3 reset to debug use with pull-up, code 3.
// - Power-on or external reset restores every pin default.
// - Peripheral functions are mapped per pin on the documented pins only.
module gpcfg_top (
  input wire i_mclk,
  input wire i_nrst,
  input wire i_wr_en,
  input wire [2:0] i_wr_port,
  input wire [4:0] i_wr_sel,
  input wire [31:0] i_wr_data,
  input wire [7:0] i_acc_mask,
  input wire i_rd_en,
  input wire [2:0] i_rd_port,
  input wire [4:0] i_rd_sel,
  output reg [31:0] o_rd_data,
  output reg o_rd_valid,
  output reg o_wr_refused,
  input wire [63:0] i_pad_in,
  output reg [63:0] o_pad_out,
  output reg [63:0] o_pad_oe,
  output wire [63:0] o_pad_pu,
  output wire [63:0] o_pad_pd,
  output wire [63:0] o_pad_ie,
  output wire [63:0] o_pad_ana,
  output reg [127:0] o_pad_drv,
  output wire [63:0] o_pad_slew,
  input wire [63:0] i_alt_out,
  input wire [63:0] i_alt_oe,
  output wire [63:0] o_alt_in,
  output reg [255:0] o_alt_code,
  output reg [7:0] o_port_irq,
  output reg o_adc_trig
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg [63:0] data;
  reg [63:0] dir;
  reg [63:0] sense;
  reg [63:0] both;
  reg [63:0] evpol;
  reg [63:0] imask;
  reg [63:0] raw;
  reg [63:0] afsel;
  reg [63:0] dr4;
  reg [63:0] dr8;
  reg [63:0] dr18;
  reg [63:0] slew;
  reg [63:0] pur;
  reg [63:0] pdr;
  reg [63:0] digital_enable_bit;
  reg [63:0] analog_mode_bit;
  reg [63:0] odr;
  reg [63:0] adcen;
  reg [255:0] pctl;

  wire [63:0] pad_sync;
  wire [63:0] pin_in;
  wire [63:0] hit;
  wire [5:0] wbase;
  wire [5:0] rbase;
  wire [7:0] wmask;
  wire [7:0] wbyte;
  wire [7:0] pres_w;
  wire [7:0] alt_w;
  wire [63:0] clr_vec;
  wire [63:0] dr18_cand;
  wire dr18_over;
  wire [63:0] next_raw;
  reg [7:0] rbyte;
  reg [63:0] rword;
  wire [7:0] pres_r;
  integer i;
  integer wi;
  integer pin;
  integer prt;

  localparam [63:0] present_map = `GPCFG_PRESENT;
  localparam [63:0] alt_map = `GPCFG_ALT_PRESENT;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Replace only the bits selected by the access mask.
  function [7:0] gpcfg_merge;
    input [7:0] old;
    input [7:0] nw;
    input [7:0] m;
    begin
      gpcfg_merge = (old & ~m) | (nw & m);
    end
  endfunction

  function [6:0] gpcfg_count;
    input [63:0] v;
    integer k;
    begin
      gpcfg_count = 7'h00;
      for (k = 0; k < 64; k = k + 1) begin
        gpcfg_count = gpcfg_count + {6'h00, v[k]};
      end
    end
  endfunction

  function [31:0] gpcfg_rst_pctl;
    input [2:0] port;
    begin
      case (port)
        3'h0: gpcfg_rst_pctl = `GPCFG_RST_PCTL_A;
        3'h1: gpcfg_rst_pctl = `GPCFG_RST_PCTL_B;
        3'h2: gpcfg_rst_pctl = `GPCFG_RST_PCTL_C;
        default: gpcfg_rst_pctl = `GPCFG_RST_PCTL_X;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Input path
  // --------------------------------------------------------------------
  gpcfg_sync2 #(.W(64)) u_sync (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_async(i_pad_in),
    .o_sync(pad_sync)
  );

  // A pin with its digital input off reads low, so only low-level or falling events can fire.
  assign pin_in = pad_sync & digital_enable_bit & `GPCFG_PRESENT;
  assign o_alt_in = pin_in;

  gpcfg_evt #(.W(64)) u_evt (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_lvl(pin_in),
    .i_sense(sense),
    .i_both(both),
    .i_event(evpol),
    .o_hit(hit)
  );

  // --------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------
  assign wbase = {i_wr_port, 3'h0};
  assign rbase = {i_rd_port, 3'h0};
  assign pres_w = present_map[wbase +: 8];
  assign alt_w = alt_map[wbase +: 8];
  assign pres_r = present_map[rbase +: 8];
  assign wmask = i_acc_mask & pres_w;
  assign wbyte = i_wr_data[7:0];
  assign clr_vec = (i_wr_en && i_wr_sel == `GPCFG_SEL_ICLR) ?
    ({56'h0, wbyte & wmask} << wbase) : 64'h0;
  // A clear in the same cycle as a new event loses to the event.
  assign next_raw = (raw & ~clr_vec) | (hit & `GPCFG_PRESENT);
  assign dr18_cand = dr18 | ({56'h0, wbyte & wmask} << wbase);
  assign dr18_over = gpcfg_count(dr18_cand) > `GPCFG_MAX_DR18;

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      // Every power-on or pin reset lands here.
      data <= 64'h0;
      dir <= 64'h0;
      sense <= 64'h0;
      both <= 64'h0;
      evpol <= 64'h0;
      imask <= 64'h0;
      raw <= 64'h0;
      afsel <= `GPCFG_RST_AFSEL;
      digital_enable_bit <= `GPCFG_RST_DEN;
      pur <= `GPCFG_RST_PUR;
      pdr <= `GPCFG_RST_PDR;
      dr4 <= 64'h0;
      dr8 <= 64'h0;
      dr18 <= 64'h0;
      slew <= 64'h0;
      analog_mode_bit <= 64'h0;
      odr <= 64'h0;
      adcen <= 64'h0;
      for (wi = 0; wi < 8; wi = wi + 1) begin
        pctl[wi*32 +: 32] <= gpcfg_rst_pctl(wi[2:0]);
      end
      o_wr_refused <= 1'b0;
      o_adc_trig <= 1'b0;
    end else begin
      raw <= next_raw;
      // Only newly raised flags start a conversion.
      o_adc_trig <= |(next_raw & ~raw & adcen);
      o_wr_refused <= 1'b0;
      if (i_wr_en) begin
        case (i_wr_sel)
          // One-cycle write path keeps a toggle every two clocks.
          `GPCFG_SEL_DATA:
            data[wbase +: 8] <= gpcfg_merge(data[wbase +: 8], wbyte, wmask);
          `GPCFG_SEL_DIR:
            dir[wbase +: 8] <= gpcfg_merge(dir[wbase +: 8], wbyte, wmask);
          `GPCFG_SEL_SENSE:
            sense[wbase +: 8] <= gpcfg_merge(sense[wbase +: 8], wbyte, wmask);
          `GPCFG_SEL_BOTH:
            both[wbase +: 8] <= gpcfg_merge(both[wbase +: 8], wbyte, wmask);
          `GPCFG_SEL_EVENT:
            evpol[wbase +: 8] <= gpcfg_merge(evpol[wbase +: 8], wbyte, wmask);
          `GPCFG_SEL_IMASK:
            imask[wbase +: 8] <= gpcfg_merge(imask[wbase +: 8], wbyte, wmask);
          `GPCFG_SEL_AFSEL:
            // Pins without a peripheral keep alternate select at zero.
            afsel[wbase +: 8] <= gpcfg_merge(afsel[wbase +: 8], wbyte,
              wmask & alt_w);
          `GPCFG_SEL_DR2: begin
            dr4[wbase +: 8] <= dr4[wbase +: 8] & ~(wbyte & wmask);
            dr8[wbase +: 8] <= dr8[wbase +: 8] & ~(wbyte & wmask);
            dr18[wbase +: 8] <= dr18[wbase +: 8] & ~(wbyte & wmask);
          end
          `GPCFG_SEL_DR4: begin
            dr4[wbase +: 8] <= dr4[wbase +: 8] | (wbyte & wmask);
            dr8[wbase +: 8] <= dr8[wbase +: 8] & ~(wbyte & wmask);
            dr18[wbase +: 8] <= dr18[wbase +: 8] & ~(wbyte & wmask);
          end
          `GPCFG_SEL_DR8: begin
            dr4[wbase +: 8] <= dr4[wbase +: 8] & ~(wbyte & wmask);
            dr8[wbase +: 8] <= dr8[wbase +: 8] | (wbyte & wmask);
            dr18[wbase +: 8] <= dr18[wbase +: 8] & ~(wbyte & wmask);
          end
          `GPCFG_SEL_DR18: begin
            // A write that would exceed four high-current pads is dropped.
            if (dr18_over) begin
              o_wr_refused <= 1'b1;
            end else begin
              dr4[wbase +: 8] <= dr4[wbase +: 8] & ~(wbyte & wmask);
              dr8[wbase +: 8] <= dr8[wbase +: 8] & ~(wbyte & wmask);
              dr18[wbase +: 8] <= dr18[wbase +: 8] | (wbyte & wmask);
            end
          end
          `GPCFG_SEL_SLEW:
            slew[wbase +: 8] <= gpcfg_merge(slew[wbase +: 8], wbyte, wmask);
          `GPCFG_SEL_PUR: begin
            // Pull-up and pull-down are exclusive; the last one wins.
            pur[wbase +: 8] <= pur[wbase +: 8] | (wbyte & wmask);
            pdr[wbase +: 8] <= pdr[wbase +: 8] & ~(wbyte & wmask);
          end
          `GPCFG_SEL_PDR: begin
            pdr[wbase +: 8] <= pdr[wbase +: 8] | (wbyte & wmask);
            pur[wbase +: 8] <= pur[wbase +: 8] & ~(wbyte & wmask);
          end
          `GPCFG_SEL_DEN:
            digital_enable_bit[wbase +: 8] <= gpcfg_merge(digital_enable_bit[wbase +: 8], wbyte, wmask);
          `GPCFG_SEL_ANALOG_MODE_BIT:
            analog_mode_bit[wbase +: 8] <= gpcfg_merge(analog_mode_bit[wbase +: 8], wbyte, wmask);
          `GPCFG_SEL_ODR:
            odr[wbase +: 8] <= gpcfg_merge(odr[wbase +: 8], wbyte, wmask);
          `GPCFG_SEL_ADCEN:
            adcen[wbase +: 8] <= gpcfg_merge(adcen[wbase +: 8], wbyte, wmask);
          `GPCFG_SEL_PCTL:
            // One nibble per pin, written only where its mask bit is set.
            for (wi = 0; wi < 8; wi = wi + 1) begin
              if (wmask[wi]) begin
                pctl[{i_wr_port, 5'h00} + wi*4 +: 4] <=
                  i_wr_data[wi*4 +: 4];
              end
            end
          default: o_wr_refused <= 1'b0;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  always @* begin
    case (i_rd_sel)
      `GPCFG_SEL_DATA: rword = (data & dir) | (pin_in & ~dir);
      `GPCFG_SEL_DIR: rword = dir;
      `GPCFG_SEL_SENSE: rword = sense;
      `GPCFG_SEL_BOTH: rword = both;
      `GPCFG_SEL_EVENT: rword = evpol;
      `GPCFG_SEL_IMASK: rword = imask;
      `GPCFG_SEL_RAW: rword = raw;
      `GPCFG_SEL_MASKED: rword = raw & imask;
      `GPCFG_SEL_AFSEL: rword = afsel;
      `GPCFG_SEL_DR2: rword = ~(dr4 | dr8 | dr18);
      `GPCFG_SEL_DR4: rword = dr4;
      `GPCFG_SEL_DR8: rword = dr8;
      `GPCFG_SEL_DR18: rword = dr18;
      `GPCFG_SEL_SLEW: rword = slew;
      `GPCFG_SEL_PUR: rword = pur;
      `GPCFG_SEL_PDR: rword = pdr;
      `GPCFG_SEL_DEN: rword = digital_enable_bit;
      `GPCFG_SEL_ANALOG_MODE_BIT: rword = analog_mode_bit;
      `GPCFG_SEL_ODR: rword = odr;
      `GPCFG_SEL_ADCEN: rword = adcen;
      default: rword = 64'h0;
    endcase
    rbyte = rword[rbase +: 8];
  end

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_data <= 32'h0000_0000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        if (i_rd_sel == `GPCFG_SEL_PCTL) begin
          o_rd_data <= pctl[{i_rd_port, 5'h00} +: 32];
        end else begin
          // Masked-off and absent pins read as zero.
          o_rd_data <= {24'h00_0000,
            rbyte & i_acc_mask & pres_r};
        end
      end else begin
        o_rd_data <= 32'h0000_0000;
      end
    end
  end

  // --------------------------------------------------------------------
  // Pad and peripheral outputs
  // --------------------------------------------------------------------
  assign o_pad_pu = pur & `GPCFG_PRESENT;
  assign o_pad_pd = pdr & `GPCFG_PRESENT;
  assign o_pad_ie = digital_enable_bit & `GPCFG_PRESENT;
  // Isolated analog use needs analog mode on; software clears the
  // digital enable itself, which is not forced here.
  assign o_pad_ana = analog_mode_bit & `GPCFG_PRESENT;
  assign o_pad_slew = slew & dr8 & `GPCFG_PRESENT;

  always @* begin
    for (i = 0; i < 64; i = i + 1) begin
      if (dr18[i]) begin
        o_pad_drv[i*2 +: 2] = `GPCFG_DRV_18MA;
      end else if (dr8[i]) begin
        o_pad_drv[i*2 +: 2] = `GPCFG_DRV_8MA;
      end else if (dr4[i]) begin
        o_pad_drv[i*2 +: 2] = `GPCFG_DRV_4MA;
      end else begin
        o_pad_drv[i*2 +: 2] = `GPCFG_DRV_2MA;
      end
      if (afsel[i] && digital_enable_bit[i]) begin
        o_alt_code[i*4 +: 4] = pctl[i*4 +: 4];
      end else begin
        o_alt_code[i*4 +: 4] = 4'h0;
      end
    end
  end

  // Open drain only ever pulls low, so a high level releases the pad.
  always @* begin
    for (pin = 0; pin < 64; pin = pin + 1) begin
      if (!present_map[pin]) begin
        o_pad_out[pin] = 1'b0;
        o_pad_oe[pin] = 1'b0;
      end else if (afsel[pin]) begin
        o_pad_out[pin] = i_alt_out[pin] & ~odr[pin];
        o_pad_oe[pin] = i_alt_oe[pin] & ~(odr[pin] & i_alt_out[pin]);
      end else begin
        o_pad_out[pin] = data[pin] & ~odr[pin];
        o_pad_oe[pin] = dir[pin] & ~(odr[pin] & data[pin]);
      end
    end
  end

  always @* begin
    for (prt = 0; prt < 8; prt = prt + 1) begin
      o_port_irq[prt] = |(raw[prt*8 +: 8] & imask[prt*8 +: 8]);
    end
  end

endmodule

// File: verification/gpcfg_checker.sv
// Port-level assertions for the pin function configuration block.
// Assumes it is bound to gpcfg_top and sees that module's ports only.
`timescale 1ns/1ns
module gpcfg_checker (
  input wire i_mclk,
  input wire i_nrst,
  input wire i_wr_en,
  input wire [4:0] i_wr_sel,
  input wire i_rd_en,
  input wire [31:0] o_rd_data,
  input wire o_rd_valid,
  input wire o_wr_refused,
  input wire [63:0] i_pad_in,
  input wire [63:0] o_pad_out,
  input wire [63:0] o_pad_oe,
  input wire [63:0] o_pad_pu,
  input wire [63:0] o_pad_pd,
  input wire [63:0] o_pad_ie,
  input wire [127:0] o_pad_drv,
  input wire [63:0] o_pad_slew,
  input wire [63:0] i_alt_out,
  input wire [63:0] i_alt_oe,
  input wire [63:0] o_alt_in,
  input wire [255:0] o_alt_code
);
  int n18;
  logic [63:0] is8;
  // The high-current limit spans all pins, so it is summed here.
  always_comb begin
    n18 = 0;
    for (int i = 0; i < 64; i++) begin
      n18 = n18 + int'(o_pad_drv[2*i+:2] == 2'h3);
      is8[i] = (o_pad_drv[2*i+:2] == 2'h2);
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  chk_rd_answer: assert property (i_rd_en |=> o_rd_valid)
    else $error("read not answered one cycle later");
  chk_rd_idle: assert property (!i_rd_en |=> !o_rd_valid && o_rd_data == 0)
    else $error("read port active without a request");
  chk_drive_limit: assert property (n18 <= 4)
    else $error("more than four pads at high current");
  chk_slew_8ma: assert property ((o_pad_slew & ~is8) == 64'h0)
    else $error("slew control on a pad not at 8 mA");
  chk_pull_excl: assert property ((o_pad_pu & o_pad_pd) == 64'h0)
    else $error("pull-up and pull-down both on");
  chk_refuse_cause: assert property (o_wr_refused |->
    $past(i_wr_en) && $past(i_wr_sel) == 5'h0c)
    else $error("refusal without a high-current write");
  chk_alt_drive: assert property (o_alt_code[3:0] != 4'h0 |->
    o_pad_oe[0] == i_alt_oe[0] && o_pad_out[0] == i_alt_out[0])
    else $error("peripheral not driving its pad");
  chk_reset_dflt: assert property ($rose(i_nrst) |->
    o_pad_pu == 64'h000f_0000 && o_pad_ie == 64'h000f_0c3f &&
    o_alt_code[95:64] == 32'h0000_3333)
    else $error("pin defaults wrong after reset");
  chk_alt_sync: assert property (o_pad_ie[0] && $past(i_nrst, 2) &&
    $past(i_nrst) |-> o_alt_in[0] == $past(i_pad_in[0], 2))
    else $error("peripheral input not two clocks behind pad");
endmodule

// File: verification/gpcfg_pads.sv
// Model of the package pads and peripherals beyond the pin block.
// Assumes the bench drives the external pad overrides at falling edges.
`timescale 1ns/1ns
module gpcfg_pads (
  input wire i_mclk,
  input wire [63:0] i_pad_out,
  input wire [63:0] i_pad_oe,
  input wire [63:0] i_pad_pu,
  input wire [63:0] i_pad_pd,
  input wire [63:0] i_ext_en,
  input wire [63:0] i_ext_val,
  output logic [63:0] o_pad_lvl,
  output logic [63:0] o_alt_out,
  output wire [63:0] o_alt_oe
);
  logic [63:0] flt = 64'h5555_5555_5555_5555;
  initial o_alt_out = 64'h0;
  // An undriven pad without a pull wanders, so it never looks stable.
  always @(posedge i_mclk) begin
    flt <= ~flt;
    o_alt_out <= ~o_alt_out;
  end
  assign o_alt_oe = 64'hffff_ffff_ffff_ffff;
  always_comb o_pad_lvl = (i_ext_en & i_ext_val) | (~i_ext_en &
    ((i_pad_oe & i_pad_out) | (~i_pad_oe & (i_pad_pu | (~i_pad_pd & flt)))));
endmodule

// File: verification/gpcfg_top_tb.sv
// Self-checking bench for the pin function configuration block.
// Assumes the design files and gpcfg_consts.vh are on the include path.
`timescale 1ns/1ns
`include "gpcfg_consts.vh"
module gpcfg_top_tb;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [2:0] i_wr_port = 3'h0;
  logic [2:0] i_rd_port = 3'h0;
  logic [4:0] i_wr_sel = 5'h00;
  logic [4:0] i_rd_sel = 5'h00;
  logic [31:0] i_wr_data = 32'h0;
  logic [7:0] i_acc_mask = 8'h00;
  logic [63:0] ext_en = 64'h0;
  logic [63:0] ext_val = 64'h0;
  wire [63:0] pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_ie, pad_ana;
  wire [63:0] pad_slew, alt_out, alt_oe, alt_in;
  wire [127:0] pad_drv;
  wire [255:0] alt_code;
  wire [31:0] rd_data;
  wire [7:0] port_irq;
  wire rd_valid, wr_refused, adc_trig;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] afd [4] = '{32'h3f, 32'h0c, 32'h0f, 32'h0};
  logic [31:0] pud [4] = '{32'h0, 32'h0, 32'h0f, 32'h0};
  logic [31:0] pcd [4] = '{32'h0011_1111, 32'h0000_1100, 32'h0000_3333, 0};

  always #10 i_mclk = ~i_mclk;
  gpcfg_top uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_wr_en(i_wr_en),
    .i_wr_port(i_wr_port), .i_wr_sel(i_wr_sel), .i_wr_data(i_wr_data),
    .i_acc_mask(i_acc_mask), .i_rd_en(i_rd_en), .i_rd_port(i_rd_port),
    .i_rd_sel(i_rd_sel), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_wr_refused(wr_refused), .i_pad_in(pad_in), .o_pad_out(pad_out),
    .o_pad_oe(pad_oe), .o_pad_pu(pad_pu), .o_pad_pd(pad_pd),
    .o_pad_ie(pad_ie), .o_pad_ana(pad_ana), .o_pad_drv(pad_drv),
    .o_pad_slew(pad_slew), .i_alt_out(alt_out), .i_alt_oe(alt_oe),
    .o_alt_in(alt_in), .o_alt_code(alt_code), .o_port_irq(port_irq),
    .o_adc_trig(adc_trig));
  gpcfg_pads far (.i_mclk(i_mclk), .i_pad_out(pad_out), .i_pad_oe(pad_oe),
    .i_pad_pu(pad_pu), .i_pad_pd(pad_pd), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_pad_lvl(pad_in), .o_alt_out(alt_out),
    .o_alt_oe(alt_oe));

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] p, input logic [4:0] s,
                    input logic [31:0] d, input logic [7:0] m);
    @(negedge i_mclk);
    i_wr_en = 1'b1;
    i_wr_port = p;
    i_wr_sel = s;
    i_wr_data = d;
    i_acc_mask = m;
    @(negedge i_mclk);
    i_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [2:0] p, input logic [4:0] s,
                    input logic [7:0] m, input logic [31:0] e);
    @(negedge i_mclk);
    i_rd_en = 1'b1;
    i_rd_port = p;
    i_rd_sel = s;
    i_acc_mask = m;
    @(negedge i_mclk);
    i_rd_en = 1'b0;
    check({31'h0, rd_valid, rd_data}, {32'h1, e});
  endtask
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (port_irq[3] !== lvl && n < 8) begin
      @(negedge i_mclk);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Hang guard and test sequence
  // ----------------------------------------------------------------------
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (16) @(negedge i_mclk);
    i_nrst = 1'b1;
    for (int p = 0; p < 4; p++) begin
      rd(p[2:0], `GPCFG_SEL_AFSEL, 8'hff, afd[p]);
      rd(p[2:0], `GPCFG_SEL_DEN, 8'hff, afd[p]);
      rd(p[2:0], `GPCFG_SEL_PUR, 8'hff, pud[p]);
      rd(p[2:0], `GPCFG_SEL_PDR, 8'hff, 32'h0);
      rd(p[2:0], `GPCFG_SEL_PCTL, 8'h00, pcd[p]);
    end
    $display("reset defaults done");
    wr(5, `GPCFG_SEL_DEN, 32'hff, 8'hff);
    rd(5, `GPCFG_SEL_DEN, 8'hff, 32'h0f);
    rd(0, 5'h1f, 8'hff, 32'h0);
    wr(3, `GPCFG_SEL_DIR, 32'h03, 8'hff);
    wr(3, `GPCFG_SEL_DATA, 32'hff, 8'h01);
    check(pad_out[25:24], 2'b01);
    rd(3, `GPCFG_SEL_DATA, 8'hff, 32'h01);
    rd(3, `GPCFG_SEL_DATA, 8'hfe, 32'h00);
    wr(3, `GPCFG_SEL_DATA, 32'h00, 8'h01);
    check(pad_out[24], 1'b0);
    wr(3, `GPCFG_SEL_DATA, 32'hff, 8'h01);
    check(pad_out[24], 1'b1);
    wr(3, `GPCFG_SEL_ODR, 32'h02, 8'h02);
    check({pad_oe[25], pad_out[25]}, 2'b10);
    $display("data and masking done");
    wr(3, `GPCFG_SEL_AFSEL, 32'h11, 8'hff);
    wr(3, `GPCFG_SEL_DEN, 32'h01, 8'h01);
    wr(3, `GPCFG_SEL_PCTL, 32'h0000_0022, 8'h01);
    rd(3, `GPCFG_SEL_AFSEL, 8'hff, 32'h01);
    check(alt_code[103:96], 8'h02);
    check(alt_code[3:0], 4'h1);
    check({pad_oe[24], pad_out[24]}, {alt_oe[24], alt_out[24]});
    $display("function select done");
    wr(3, `GPCFG_SEL_DR18, 32'h0f, 8'hff);
    wr(4, `GPCFG_SEL_DR18, 32'h01, 8'hff);
    check(wr_refused, 1'b1);
    check({pad_drv[65:64], pad_drv[49:48]}, 4'h3);
    wr(3, `GPCFG_SEL_DR8, 32'h20, 8'hff);
    wr(3, `GPCFG_SEL_SLEW, 32'h60, 8'hff);
    check(pad_slew[30:29], 2'b01);
    wr(2, `GPCFG_SEL_PDR, 32'h01, 8'h01);
    check({pad_pu[16], pad_pd[16]}, 2'b01);
    wr(4, `GPCFG_SEL_ANALOG_MODE_BIT, 32'h02, 8'h02);
    check({pad_ana[33], pad_ie[33]}, 2'b10);
    wr(1, `GPCFG_SEL_DEN, 32'h10, 8'h10);
    wr(1, `GPCFG_SEL_DEN, 32'h00, 8'h10);
    check({pad_ana[12], pad_ie[12]}, 2'b00);
    $display("pad options done");
    ext_en[28] = 1'b1;
    // D0 follows a toggling peripheral, so its input is shut off here.
    wr(3, `GPCFG_SEL_DEN, 32'h10, 8'h11);
    wr(3, `GPCFG_SEL_EVENT, 32'h10, 8'hff);
    wr(3, `GPCFG_SEL_ADCEN, 32'h10, 8'hff);
    wr(3, `GPCFG_SEL_ICLR, 32'hff, 8'hff);
    wr(3, `GPCFG_SEL_IMASK, 32'h10, 8'hff);
    check(port_irq[3], 1'b0);
    ext_val[28] = 1'b1;
    wait_irq(1'b1);
    check(port_irq[3], 1'b1);
    check(adc_trig, 1'b1);
    check(alt_in[28], 1'b1);
    rd(3, `GPCFG_SEL_RAW, 8'hff, 32'h10);
    rd(3, `GPCFG_SEL_MASKED, 8'hef, 32'h00);
    wr(3, `GPCFG_SEL_ICLR, 32'h10, 8'hff);
    check(port_irq[3], 1'b0);
    wr(3, `GPCFG_SEL_BOTH, 32'h10, 8'hff);
    ext_val[28] = 1'b0;
    wait_irq(1'b1);
    check(port_irq[3], 1'b1);
    wr(3, `GPCFG_SEL_IMASK, 32'h00, 8'hff);
    check(port_irq[3], 1'b0);
    wr(3, `GPCFG_SEL_SENSE, 32'h10, 8'hff);
    wr(3, `GPCFG_SEL_BOTH, 32'h00, 8'hff);
    wr(3, `GPCFG_SEL_EVENT, 32'h00, 8'hff);
    wr(3, `GPCFG_SEL_ICLR, 32'h10, 8'hff);
    wr(3, `GPCFG_SEL_IMASK, 32'h10, 8'hff);
    repeat (2) @(negedge i_mclk);
    check(port_irq[3], 1'b1);
    ext_val[28] = 1'b1;
    repeat (4) @(negedge i_mclk);
    wr(3, `GPCFG_SEL_ICLR, 32'h10, 8'hff);
    repeat (2) @(negedge i_mclk);
    check(port_irq[3], 1'b0);
    $display("interrupts done");
    i_nrst = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_nrst = 1'b1;
    check(pad_drv[127:64] | pad_drv[63:0], 64'h0);
    check(pad_pu, 64'h000f_0000);
    check(pad_ana, 64'h0);
    rd(3, `GPCFG_SEL_PCTL, 8'hff, 32'h0);
    $display("second reset done");
    tally_and_finish;
  end
endmodule

bind gpcfg_top gpcfg_checker chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_wr_en(i_wr_en), .i_wr_sel(i_wr_sel), .i_rd_en(i_rd_en),
  .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
  .o_wr_refused(o_wr_refused), .i_pad_in(i_pad_in), .o_pad_out(o_pad_out),
  .o_pad_oe(o_pad_oe), .o_pad_pu(o_pad_pu), .o_pad_pd(o_pad_pd),
  .o_pad_ie(o_pad_ie), .o_pad_drv(o_pad_drv), .o_pad_slew(o_pad_slew),
  .i_alt_out(i_alt_out), .i_alt_oe(i_alt_oe), .o_alt_in(o_alt_in),
  .o_alt_code(o_alt_code));
